// File: design/pbo_pkg.sv
/*
 Constants, register map and helper function of the parallel BCD/binary
 output port. Assumes a 100 MHz core clock unless the top says otherwise.
*/
package pbo_pkg;
	localparam int          ADDR_W        = 4;
	localparam int          BUS_W         = 32;
	localparam logic [3:0]  ADDR_CTRL     = 4'h0;
	localparam logic [3:0]  ADDR_IRQ_ST   = 4'h4;
	localparam logic [3:0]  ADDR_IRQ_MASK = 4'h8;
	localparam logic [3:0]  ADDR_STATE    = 4'hC;

	localparam int          RATE_LSB      = 0;
	localparam int          RATE_W        = 3;
	localparam int          FMT_BIT       = 4;
	localparam int          SRC_LSB       = 8;
	localparam int          SRC_W         = 3;
	localparam logic [2:0]  RATE_RST      = 3'h3;
	localparam logic        FMT_BCD       = 1'h0;
	localparam logic        FMT_BIN       = 1'h1;

	localparam logic [2:0]  SRC_HOLD      = 3'h0;
	localparam logic [2:0]  SRC_SPEED     = 3'h1;
	localparam logic [2:0]  SRC_ANGLE     = 3'h2;
	localparam logic [2:0]  SRC_RT        = 3'h3;
	localparam logic [2:0]  SRC_EXT       = 3'h4;
	localparam logic [2:0]  SRC_RST       = SRC_HOLD;

	localparam int          IRQ_W         = 3;
	localparam int          IRQ_UPD       = 0;
	localparam int          IRQ_OVR       = 1;
	localparam int          IRQ_FRZ       = 2;

	localparam int          STATE_SRC_LSB = 0;
	localparam int          STATE_FRZ_BIT = 4;
	localparam int          STATE_POS_BIT = 5;

	localparam int          DATA_W        = 20;
	localparam int          BIN_W         = 17;
	localparam int          DIG_W         = 4;
	localparam int          DIGITS        = 5;
	localparam int          RESP_LSB      = 18;
	localparam logic [16:0] MAG_MAX       = 17'h1869F;
	localparam logic [3:0]  BCD_ADJ_MIN   = 4'h5;
	localparam logic [3:0]  BCD_ADJ       = 4'h3;

	localparam int          CNT_W         = 32;
	localparam int          STROBE_SHIFT  = 2;
	localparam int          CLK_HZ_DEF    = 100_000_000;
	localparam int          RATE0_HZ      = 10;
	localparam int          RATE1_HZ      = 25;
	localparam int          RATE2_HZ      = 50;
	localparam int          RATE3_HZ      = 100;
	localparam int          RATE4_HZ      = 250;
	localparam int          RATE5_HZ      = 500;
	localparam int          RATE6_HZ      = 1000;

	// Codes above 6 fall back to the fastest rate.
	function automatic int rate_cycles(input logic [2:0] code,
		input int clk_hz);
		int hz;
		case (code)
			3'h0: hz = RATE0_HZ;
			3'h1: hz = RATE1_HZ;
			3'h2: hz = RATE2_HZ;
			3'h3: hz = RATE3_HZ;
			3'h4: hz = RATE4_HZ;
			3'h5: hz = RATE5_HZ;
			default: hz = RATE6_HZ;
		endcase
		return clk_hz / hz;
	endfunction
endpackage

// File: design/pbo_sync.sv
/*
 Two-flop synchroniser for a group of independent level inputs.
 Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/1ns
module pbo_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

// File: design/pbo_bin2bcd.sv
/*
 Combinational binary to five-digit BCD converter (shift and add three).
 Assumes the input is already clamped to the five-digit range.
*/
`timescale 1ns/1ns
module pbo_bin2bcd (
	input  wire logic [pbo_pkg::BIN_W-1:0]  bin,
	output logic      [pbo_pkg::DATA_W-1:0] bcd
);
	localparam int SH_W = pbo_pkg::BIN_W + pbo_pkg::DATA_W;
	logic [SH_W-1:0] sh;

	always_comb begin
		sh = '0;
		sh[pbo_pkg::BIN_W-1:0] = bin;
		for (int i = 0; i < pbo_pkg::BIN_W; i++) begin
			for (int d = 0; d < pbo_pkg::DIGITS; d++) begin
				if (sh[pbo_pkg::BIN_W+d*pbo_pkg::DIG_W +: pbo_pkg::DIG_W]
					>= pbo_pkg::BCD_ADJ_MIN) begin
					sh[pbo_pkg::BIN_W+d*pbo_pkg::DIG_W +: pbo_pkg::DIG_W] =
						sh[pbo_pkg::BIN_W+d*pbo_pkg::DIG_W +: pbo_pkg::DIG_W]
						+ pbo_pkg::BCD_ADJ;
				end
			end
			sh = {sh[SH_W-2:0], 1'b0};
		end
		bcd = sh[pbo_pkg::BIN_W +: pbo_pkg::DATA_W];
	end
endmodule

// File: design/pbo_port.sv
/*
 Isolated parallel output port: presents the chosen measurement as BCD or
 binary with sign, over-scale, stable and strobe lines, plus a small
 register file with a sticky interrupt.
 Assumes measurement inputs are on core_clk; receiver pins are asynchronous.
*/
`timescale 1ns/1ns
// How it works
// - Minus line follows sign of presented value.
// - Over line shows over-scale or input overload.
// - Stable line follows motion detector verdict.
// - One strobe per update, centred on data.
// - Polarity pin sets logic of all output pins.
// - Freeze holds data, forces strobe off.
// - Rate codes 0..6 map 10..1000/s, default 3.
// - Rate changes only port refresh, not sampling.
// - Format selects BCD (0) or binary (1).
// - Binary mode echoes selected source on two lines.
// - Source setting or external pins choose data.
module pbo_port #(
	parameter int CORE_CLK_HZ = pbo_pkg::CLK_HZ_DEF
) (
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	input  wire logic [pbo_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [pbo_pkg::BUS_W-1:0]   reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [pbo_pkg::BUS_W-1:0]   reg_rdata,
	output logic                             irq,
	input  wire logic [pbo_pkg::BIN_W-1:0]   mag_hold,
	input  wire logic                        neg_hold,
	input  wire logic [pbo_pkg::BIN_W-1:0]   mag_speed,
	input  wire logic                        neg_speed,
	input  wire logic [pbo_pkg::BIN_W-1:0]   mag_angle,
	input  wire logic                        neg_angle,
	input  wire logic [pbo_pkg::BIN_W-1:0]   mag_rt,
	input  wire logic                        neg_rt,
	input  wire logic                        overload_in,
	input  wire logic                        stable_in,
	input  wire logic                        freeze_pin,
	input  wire logic                        pos_logic_pin,
	input  wire logic [1:0]                  sel_pin,
	output logic      [pbo_pkg::DATA_W-1:0]  data_pins,
	output logic                             minus_pin,
	output logic                             over_pin,
	output logic                             stable_flag_pin,
	output logic                             strobe_pin
);
	logic [1:0]                 sel_s;
	logic                       pos_s;
	logic                       frz_s;
	logic [2:0]                 rate_r;
	logic                       fmt_r;
	logic [2:0]                 src_r;
	logic [pbo_pkg::IRQ_W-1:0]  irq_st_r;
	logic [pbo_pkg::IRQ_W-1:0]  irq_mask_r;
	logic [pbo_pkg::CNT_W-1:0]  cnt_r;
	logic [pbo_pkg::DATA_W-1:0] word_r;
	logic                       neg_r;
	logic                       ovr_r;
	logic                       stable_flag_r;
	logic                       frz_d_r;

	pbo_sync #(
		.W(4)
	) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.async_in ({sel_pin, pos_logic_pin, freeze_pin}),
		.sync_out ({sel_s, pos_s, frz_s})
	);

	// Register decode.
	wire wr_ctrl = reg_wr && (reg_addr == pbo_pkg::ADDR_CTRL);
	wire wr_st   = reg_wr && (reg_addr == pbo_pkg::ADDR_IRQ_ST);
	wire wr_mask = reg_wr && (reg_addr == pbo_pkg::ADDR_IRQ_MASK);

	// Source selection; external mode follows the synchronised pins.
	wire       src_is_ext = (src_r == pbo_pkg::SRC_EXT);
	wire [1:0] src_eff    = src_is_ext ? sel_s :
		((src_r > pbo_pkg::SRC_EXT) ? pbo_pkg::SRC_HOLD[1:0] : src_r[1:0]);
	wire [pbo_pkg::BIN_W-1:0] mag_sel =
		(src_eff == pbo_pkg::SRC_SPEED[1:0]) ? mag_speed :
		(src_eff == pbo_pkg::SRC_ANGLE[1:0]) ? mag_angle :
		(src_eff == pbo_pkg::SRC_RT[1:0])    ? mag_rt : mag_hold;
	wire neg_sel =
		(src_eff == pbo_pkg::SRC_SPEED[1:0]) ? neg_speed :
		(src_eff == pbo_pkg::SRC_ANGLE[1:0]) ? neg_angle :
		(src_eff == pbo_pkg::SRC_RT[1:0])    ? neg_rt : neg_hold;

	// Values beyond five digits cannot be shown in BCD, so they saturate
	// and count as over-scale; binary holds the full range.
	wire in_bcd   = (fmt_r == pbo_pkg::FMT_BCD);
	wire too_big  = in_bcd && (mag_sel > pbo_pkg::MAG_MAX);
	wire over_cap = overload_in || too_big;
	wire [pbo_pkg::BIN_W-1:0]  mag_clamp = too_big ? pbo_pkg::MAG_MAX : mag_sel;
	wire [pbo_pkg::DATA_W-1:0] bcd_word;

	pbo_bin2bcd u_bcd (
		.bin (mag_clamp),
		.bcd (bcd_word)
	);

	wire [pbo_pkg::DATA_W-1:0] bin_word =
		{src_eff, 1'b0, mag_sel};
	wire [pbo_pkg::DATA_W-1:0] word_nxt =
		in_bcd ? bcd_word : bin_word;

	// The divider only paces the port; measurement inputs keep flowing
	// at the core rate whatever the setting.
	wire [pbo_pkg::CNT_W-1:0] period =
		pbo_pkg::CNT_W'(pbo_pkg::rate_cycles(rate_r, CORE_CLK_HZ));
	wire [pbo_pkg::CNT_W-1:0] quarter = period >> pbo_pkg::STROBE_SHIFT;
	wire upd     = (cnt_r == '0);
	wire capture = upd && !frz_s;
	// Strobe sits in the middle half so both of its edges are clear of
	// the data change at the period boundary.
	wire stb_act = !frz_s && (cnt_r >= quarter) &&
		(cnt_r < period - quarter);

	wire [pbo_pkg::IRQ_W-1:0] ev;
	assign ev[pbo_pkg::IRQ_UPD] = capture;
	assign ev[pbo_pkg::IRQ_OVR] = capture && over_cap && !ovr_r;
	assign ev[pbo_pkg::IRQ_FRZ] = frz_s && !frz_d_r;
	wire [pbo_pkg::IRQ_W-1:0] irq_st_nxt =
		(irq_st_r & ~(wr_st ? reg_wdata[pbo_pkg::IRQ_W-1:0] : '0)) | ev;

	wire [pbo_pkg::BUS_W-1:0] ctrl_rd =
		pbo_pkg::BUS_W'({src_r, 3'h0, fmt_r, 1'b0, rate_r});
	wire [pbo_pkg::BUS_W-1:0] state_rd =
		pbo_pkg::BUS_W'({pos_s, frz_s, 2'h0, src_eff});
	wire [pbo_pkg::BUS_W-1:0] rd_nxt =
		!reg_rd ? '0 :
		(reg_addr == pbo_pkg::ADDR_CTRL)     ? ctrl_rd :
		(reg_addr == pbo_pkg::ADDR_IRQ_ST)   ? pbo_pkg::BUS_W'(irq_st_r) :
		(reg_addr == pbo_pkg::ADDR_IRQ_MASK) ? pbo_pkg::BUS_W'(irq_mask_r) :
		(reg_addr == pbo_pkg::ADDR_STATE)    ? state_rd : '0;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rate_r     <= pbo_pkg::RATE_RST;
			fmt_r      <= pbo_pkg::FMT_BCD;
			src_r      <= pbo_pkg::SRC_RST;
			irq_mask_r <= '0;
		end else if (wr_ctrl) begin
			rate_r <= reg_wdata[pbo_pkg::RATE_LSB +: pbo_pkg::RATE_W];
			fmt_r  <= reg_wdata[pbo_pkg::FMT_BIT];
			src_r  <= reg_wdata[pbo_pkg::SRC_LSB +: pbo_pkg::SRC_W];
		end else if (wr_mask) begin
			irq_mask_r <= reg_wdata[pbo_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_st_r  <= '0;
			irq       <= 1'b0;
			reg_rdata <= '0;
			frz_d_r   <= 1'b0;
		end else begin
			irq_st_r  <= irq_st_nxt;
			irq       <= |(irq_st_r & irq_mask_r);
			reg_rdata <= rd_nxt;
			frz_d_r   <= frz_s;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || wr_ctrl || upd) begin
			cnt_r <= (!rst_n || wr_ctrl) ? '0 : period - 1'b1;
		end else begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			word_r <= '0;
			neg_r  <= 1'b0;
			ovr_r  <= 1'b0;
			stable_flag_r <= 1'b0;
		end else if (capture) begin
			word_r <= word_nxt;
			neg_r  <= neg_sel;
			ovr_r  <= over_cap;
			stable_flag_r <= stable_in;
		end
	end

	// Pins idle high, the inactive level of negative logic.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			data_pins       <= '1;
			minus_pin       <= 1'b1;
			over_pin        <= 1'b1;
			stable_flag_pin <= 1'b1;
			strobe_pin      <= 1'b1;
		end else begin
			data_pins       <= pos_s ? word_r : ~word_r;
			minus_pin       <= pos_s ? neg_r : !neg_r;
			over_pin        <= pos_s ? ovr_r : !ovr_r;
			stable_flag_pin <= pos_s ? stable_flag_r : !stable_flag_r;
			strobe_pin      <= pos_s ? stb_act : !stb_act;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// A capture of an over-scale value, then the latched flag one cycle on.
	sequence s_over_seen;
		capture && over_cap ##1 ovr_r;
	endsequence

	sign_line_a: assert property (
		minus_pin == ($past(pos_s) ? $past(neg_r) : !$past(neg_r)))
		else $error("minus line does not follow sign");
	over_capture_a: assert property (
		s_over_seen |=> over_pin == $past(pos_s))
		else $error("over-scale not shown");
	stable_capture_a: assert property (
		capture |=> stable_flag_r == $past(stable_in))
		else $error("stable flag not captured");
	strobe_clear_a: assert property (
		upd |-> !stb_act ##1 !stb_act)
		else $error("strobe active at data change");
	pol_data_a: assert property (
		data_pins == ($past(pos_s) ? $past(word_r) : ~$past(word_r)))
		else $error("polarity not applied to data");
	freeze_hold_a: assert property (
		frz_s |=> $stable(word_r) && strobe_pin == !$past(pos_s))
		else $error("freeze did not hold data or strobe");
	rate_reset_a: assert property (
		$rose(rst_n) |-> rate_r == pbo_pkg::RATE_RST)
		else $error("rate setting not at default");
	reload_a: assert property (
		upd && !wr_ctrl |=> cnt_r == $past(period) - 1'b1)
		else $error("divider reload wrong");
	bin_word_a: assert property (
		capture && fmt_r |=> word_r[pbo_pkg::BIN_W-1:0]
		== $past(mag_sel))
		else $error("binary word wrong");
	resp_lines_a: assert property (
		capture && fmt_r |=> word_r[pbo_pkg::RESP_LSB +: 2] == $past(src_eff))
		else $error("source echo wrong");
	ext_select_a: assert property (
		src_is_ext |-> src_eff == sel_s)
		else $error("external select ignored");
endmodule

// File: verif/pbo_rx_model.sv
/*
 Receiver card model: latches the output pins at the strobe edge that
 ends the active half and times the spacing of those edges.
 Assumes it sees the pins through the core clock, like a polled input card.
*/
`timescale 1ns/1ns
module pbo_rx_model (
	input  wire logic        core_clk,
	input  wire logic        pos_logic,
	input  wire logic [22:0] pins,
	input  wire logic        strobe_pin,
	output logic      [22:0] word,
	output int               n_samp,
	output int               period
);
	logic strobe_q;
	int   age;
	wire  ends_active;

	// The card reads on the rising edge in negative logic, else falling.
	assign ends_active = pos_logic ? (strobe_q & ~strobe_pin)
	                               : (~strobe_q & strobe_pin);

	initial begin
		strobe_q = 1'b1;
		age = 0;
		n_samp = 0;
		period = 0;
		word = 23'h0;
	end

	always @(posedge core_clk) begin
		strobe_q <= strobe_pin;
		age <= ends_active ? 1 : age + 1;
		if (ends_active) begin
			word <= pins;
			n_samp <= n_samp + 1;
			period <= age;
		end
	end
endmodule

// File: verif/tb.sv
/*
 Self-checking bench of the parallel output port with a receiver model.
 Assumes pbo_pkg, the design and pbo_rx_model are compiled before it.
*/
`timescale 1ns/1ns
module tb;
	localparam int HZ = 40000;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [16:0] mag [4] = '{17'h03039, 17'h0F0F0, 17'h1869F, 17'h0D431};
	logic [3:0]  neg = 4'h5;
	logic        ovl = 1'b0;
	logic        stb = 1'b0;
	logic        frz = 1'b0;
	logic        pos = 1'b0;
	logic [1:0]  sel = 2'h0;
	logic [31:0] reg_rdata;
	logic [19:0] data_pins;
	logic        irq, minus_pin, over_pin, stable_flag_pin, strobe_pin;
	logic [22:0] rx_word;
	logic [19:0] snap;
	logic [22:0] exp_w;
	int          rx_n, rx_per, bad_count, total_checks, n0;
	int          hz [7] = '{10, 25, 50, 100, 250, 500, 1000};

	always #5 core_clk = ~core_clk;

	pbo_port #(.CORE_CLK_HZ(HZ)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.mag_hold(mag[0]), .neg_hold(neg[0]), .mag_speed(mag[1]),
		.neg_speed(neg[1]), .mag_angle(mag[2]), .neg_angle(neg[2]),
		.mag_rt(mag[3]), .neg_rt(neg[3]), .overload_in(ovl),
		.stable_in(stb), .freeze_pin(frz), .pos_logic_pin(pos),
		.sel_pin(sel), .data_pins(data_pins), .minus_pin(minus_pin),
		.over_pin(over_pin), .stable_flag_pin(stable_flag_pin),
		.strobe_pin(strobe_pin));

	pbo_rx_model u_rx (.core_clk(core_clk), .pos_logic(pos),
		.pins({stable_flag_pin, over_pin, minus_pin, data_pins}),
		.strobe_pin(strobe_pin), .word(rx_word), .n_samp(rx_n),
		.period(rx_per));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		chk(reg_rdata, e);
	endtask

	// Waits for n receiver samples; a stuck strobe ends the run.
	task automatic samp(input int n);
		int t0;
		t0 = rx_n;
		for (int i = 0; i < 30000 && rx_n < t0 + n; i++)
			@(posedge core_clk);
		if (rx_n < t0 + n) begin
			bad_count++;
			end_sim();
		end
	endtask

	task automatic settle();
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	function automatic logic [22:0] px(input logic [22:0] v);
		return pos ? v : ~v;
	endfunction

	function automatic logic [19:0] bcd(input int v);
		logic [19:0] r;
		for (int k = 0; k < 5; k++) begin
			r[4*k+:4] = 4'(v % 10);
			v = v / 10;
		end
		return r;
	endfunction

	initial begin
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		chk({strobe_pin, stable_flag_pin, over_pin, minus_pin, data_pins},
			32'hFFFFFF);
		@(posedge core_clk);
		rst_n <= 1'b1;
		rchk(pbo_pkg::ADDR_CTRL, 32'h3);
		rchk(4'h2, 32'h0);
		for (int c = 0; c < 7; c++) begin
			wr(pbo_pkg::ADDR_CTRL, 32'(c));
			samp(3);
			chk(32'(rx_per), 32'(HZ / hz[c]));
		end
		for (int p = 0; p < 2; p++)
			for (int e = 0; e < 2; e++)
				for (int f = 0; f < 2; f++)
					for (int s = 0; s < 4; s++) begin
						pos <= p[0];
						sel <= s[1:0];
						stb <= f[0];
						wr(pbo_pkg::ADDR_CTRL, {21'h0, (e != 0) ? 3'h4 : 3'(s),
							3'h0, f[0], 4'h6});
						samp(3);
						exp_w = px({f[0], 1'b0, neg[s], (f != 0) ?
							{2'(s), 1'b0, mag[s]} : bcd(int'(mag[s]))});
						chk(rx_word[19:0], exp_w[19:0]);
						chk(rx_word[22:20], exp_w[22:20]);
						rchk(pbo_pkg::ADDR_STATE, {26'h0, p[0], 3'h0, 2'(s)});
					end
		wr(pbo_pkg::ADDR_CTRL, 32'h306);
		mag[3] <= 17'h1FFFF;
		samp(3);
		chk(32'(rx_word), 32'(px({2'h3, neg[3], 20'h99999})));
		mag[3] <= 17'h00005;
		ovl <= 1'b1;
		samp(3);
		chk(32'(rx_word), 32'(px({2'h3, neg[3], 20'h00005})));
		wr(pbo_pkg::ADDR_IRQ_MASK, 32'h0);
		wr(pbo_pkg::ADDR_IRQ_ST, 32'h7);
		samp(2);
		chk(irq, 1'b0);
		wr(pbo_pkg::ADDR_IRQ_MASK, 32'h1);
		settle();
		chk(irq, 1'b1);
		wr(pbo_pkg::ADDR_IRQ_MASK, 32'h4);
		wr(pbo_pkg::ADDR_IRQ_ST, 32'h7);
		settle();
		chk(irq, 1'b0);
		frz <= 1'b1;
		repeat (200) @(posedge core_clk);
		chk(irq, 1'b1);
		rchk(pbo_pkg::ADDR_STATE, 32'h33);
		n0 = rx_n;
		snap = data_pins;
		mag[3] <= 17'h00777;
		repeat (200) @(posedge core_clk);
		chk(32'(rx_n), 32'(n0));
		chk(data_pins, snap);
		chk(strobe_pin, !pos);
		wr(pbo_pkg::ADDR_IRQ_ST, 32'h4);
		settle();
		chk(irq, 1'b0);
		frz <= 1'b0;
		samp(3);
		chk(32'(rx_word[19:0]), 32'(px({3'h0, 20'h01911})));
		end_sim();
	end
endmodule
